//--- rtl/ommd_cfg_if.sv
// interface: decoder configuration shared between bus slave and decoder
// assumes one clock domain
`timescale 1ns/10ps
interface ommd_cfg_if;
  logic periph_en; // on-chip peripheral enable
  logic [15:0] stack_pointer_reg; // current stack pointer
  logic [15:0] ovf_limit; // stack overflow limit
  logic [15:0] unf_limit; // stack underflow limit
  logic [23:0] win_base [4]; // external window bases
  logic [23:0] win_mask [4]; // external window masks
  modport src (output periph_en, stack_pointer_reg, ovf_limit, unf_limit,
    win_base, win_mask);
  modport dst (input periph_en, stack_pointer_reg, ovf_limit, unf_limit,
    win_base, win_mask);
endinterface

//--- rtl/ommd_decoder.sv
// What this block does
// - one linear 16 Mbyte space for everything
// - byte and word access everywhere, some bits
// - 2 Kbyte internal ram for data, stack, banks
// - bank holds 16 words, low eight byte-split
// - context base selects bank, overlap allowed
// - extension ram: zero wait demux access
// - enable bit 2 maps extension ram E000-E7FF
// - extension ram: no stack, bank, bit access
// - disabled extension ram goes to external bus
// - two 512-byte function register areas
// - can window EF00-EFFF, same enable bit
// - can access: two wait states, byte ok
// - can in use limits segment lines to four
// - external bus reaches the full 16 Mbyte
// - 32 Kbyte on-chip rom mapped
// - system stack up to 1 Kbyte in internal ram
// - stack pointer checked against both limits
// - uncovered external address uses default config
// file: top of the decoder with its axi4-lite register slave
// assumes the cpu holds an access until acc_done
//
// The AXI4-Lite interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/10ps
module ommd_decoder (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic acc_req,
  input wire logic [23:0] acc_addr,
  input wire logic acc_word,
  input wire logic acc_bit,
  input wire logic acc_stack,
  input wire logic [3:0] acc_gpr,
  input wire logic acc_gpr_en,
  input wire logic acc_gpr_byte,
  input wire logic acc_gpr_high,
  output logic acc_done,
  output logic [2:0] acc_target,
  output logic [23:0] acc_phys,
  output logic [1:0] acc_lanes,
  output logic [2:0] acc_busconf,
  output logic [3:0] seg_lines,
  output logic acc_fault,
  output logic stack_ovf,
  output logic stack_unf
);
  ommd_cfg_if cfg ();
  // software-visible state
  logic [15:0] syscfg; // system_config_reg
  logic [15:0] context_base_pointer; // active bank base
  logic [15:0] stack_pointer_reg; // stack pointer
  logic [15:0] stack_overflow_limit; // lower bound
  logic [15:0] stack_underflow_limit; // upper bound
  logic [23:0] wbase [4]; // address_window_select_reg bases
  logic [23:0] wmask [4]; // window masks
  assign cfg.periph_en = syscfg[ommd_pkg::PERIPH_EN_BIT];
  assign cfg.stack_pointer_reg = stack_pointer_reg;
  assign cfg.ovf_limit = stack_overflow_limit;
  assign cfg.unf_limit = stack_underflow_limit;
  assign cfg.win_base = wbase;
  assign cfg.win_mask = wmask;

  // ---------------- decode path ----------------
  logic [23:0] eff_addr; // address after bank/byte mapping
  logic [23:0] gpr_addr; // register bank slot address
  logic [15:0] gpr_off; // byte offset inside bank
  // low eight registers split into byte halves; word regs are 2 apart
  assign gpr_off = acc_gpr_byte ?
    {12'h000, acc_gpr[2:0], acc_gpr_high} : {11'h000, acc_gpr, 1'b0};
  assign gpr_addr = {8'h00, context_base_pointer + gpr_off};
  assign eff_addr = acc_gpr_en ? gpr_addr : acc_addr;
  wire in_iram = eff_addr >= ommd_pkg::IRAM_BASE &&
    eff_addr <= ommd_pkg::IRAM_LAST;
  wire in_extension_ram = eff_addr >= ommd_pkg::EXTENSION_RAM_BASE &&
    eff_addr <= ommd_pkg::EXTENSION_RAM_LAST;
  wire in_can = eff_addr >= ommd_pkg::CAN_BASE &&
    eff_addr <= ommd_pkg::CAN_LAST;
  wire in_sfr = (eff_addr >= ommd_pkg::SFR_BASE &&
    eff_addr <= ommd_pkg::SFR_LAST) || (eff_addr >= ommd_pkg::EXTENDED_FUNCTION_REGS_BASE &&
    eff_addr <= ommd_pkg::EXTENDED_FUNCTION_REGS_LAST);
  wire in_rom = eff_addr <= ommd_pkg::ROM_LAST;
  wire extension_ram_on = in_extension_ram && cfg.periph_en;
  wire can_on = in_can && cfg.periph_en;
  // priority: on-chip regions win, the rest goes out
  wire [2:0] tgt = in_sfr ? 3'(ommd_pkg::OMMD_T_SFR) :
    in_iram ? 3'(ommd_pkg::OMMD_T_IRAM) :
    extension_ram_on ? 3'(ommd_pkg::OMMD_T_EXTENSION_RAM) :
    can_on ? 3'(ommd_pkg::OMMD_T_CAN) :
    in_rom ? 3'(ommd_pkg::OMMD_T_ROM) :
    3'(ommd_pkg::OMMD_T_EXT);
  // stack and bank access only valid inside internal ram; bit access inside internal ram or sfr
  wire bad_kind = (acc_stack || acc_gpr_en) &&
    (tgt != 3'(ommd_pkg::OMMD_T_IRAM));
  wire bad_bit = acc_bit && tgt != 3'(ommd_pkg::OMMD_T_IRAM) &&
    tgt != 3'(ommd_pkg::OMMD_T_SFR);
  // word accesses use both lanes; byte accesses pick by a0
  wire [1:0] lanes = acc_word ? 2'h3 : (eff_addr[0] ? 2'h2 : 2'h1);
  wire [2:0] win_sel; // external config selection
  ommd_region_match u_match (
    .addr(eff_addr),
    .cfg(cfg),
    .win_sel(win_sel)
  );
  // stack limit comparisons on the current pointer
  wire sp_ovf = acc_stack && cfg.stack_pointer_reg < cfg.ovf_limit;
  wire sp_unf = acc_stack && cfg.stack_pointer_reg > cfg.unf_limit;

  // ---------------- access sequencer ----------------
  typedef enum logic [1:0] {
    OMMD_S_IDLE = 2'b00,
    OMMD_S_WAIT = 2'b01,
    OMMD_S_DONE = 2'b10
  } ommd_state_t;
  ommd_state_t state;
  ommd_state_t next_state;
  logic [7:0] wait_cnt; // remaining wait cycles
  wire [7:0] wait_need = (tgt == 3'(ommd_pkg::OMMD_T_CAN)) ?
    8'(ommd_pkg::CAN_WAIT_CYC) : 8'(ommd_pkg::EXTENSION_RAM_WAIT);
  // next-state selection
  always_comb begin
    next_state = state;
    case (state)
      OMMD_S_IDLE: begin
        if (acc_req) begin
          next_state = (wait_need == 8'h00) ? OMMD_S_DONE : OMMD_S_WAIT;
        end
      end
      OMMD_S_WAIT: begin
        if (wait_cnt == 8'h01) begin
          next_state = OMMD_S_DONE;
        end
      end
      OMMD_S_DONE: begin
        next_state = OMMD_S_IDLE;
      end
      default: begin
        next_state = OMMD_S_IDLE;
      end
    endcase
  end
  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= OMMD_S_IDLE;
    end else begin
      state <= next_state;
    end
  end
  // wait counter loads on the accepting edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wait_cnt <= 8'h00;
    end else if (state == OMMD_S_IDLE && acc_req) begin
      wait_cnt <= wait_need;
    end else if (wait_cnt != 8'h00) begin
      wait_cnt <= wait_cnt - 8'h01;
    end
  end
  // routing results latched at acceptance, held until done
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_target <= 3'h0;
      acc_phys <= 24'h000000;
      acc_lanes <= 2'h0;
      acc_busconf <= 3'h0;
      acc_fault <= 1'b0;
    end else if (state == OMMD_S_IDLE && acc_req) begin
      acc_target <= tgt;
      acc_phys <= eff_addr;
      acc_lanes <= lanes;
      acc_busconf <= win_sel;
      acc_fault <= bad_kind || bad_bit;
    end
  end
  // completion pulse
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_done <= 1'b0;
    end else begin
      acc_done <= (next_state == OMMD_S_DONE);
    end
  end
  // segment lines limited while can is enabled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seg_lines <= 4'h8;
    end else begin
      seg_lines <= cfg.periph_en ? 4'(ommd_pkg::EXT_SEG_CAN) :
        4'(ommd_pkg::EXT_SEG_FULL);
    end
  end

  // ---------------- axi4-lite slave ----------------
  logic aw_held; // write address captured
  logic w_held; // write data captured
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  wire wr_go = aw_held && w_held && !s_axi_bvalid;
  wire [7:0] ra = s_axi_araddr[7:0];
  wire map_w = aw_addr <= ommd_pkg::A_STATUS ||
    (aw_addr >= ommd_pkg::A_WIN0 && aw_addr < 8'h40);
  wire [1:0] wi = aw_addr[4:3]; // window index
  wire w_clr = wr_go && aw_addr == ommd_pkg::A_STATUS;
  wire next_aw_held = (s_axi_awvalid && s_axi_awready) ||
    (aw_held && !wr_go); // ready flop mirrors its inverse
  wire next_w_held = (s_axi_wvalid && s_axi_wready) ||
    (w_held && !wr_go); // ready flop mirrors its inverse
  // accept channels independently, one write in flight
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
    end else begin
      s_axi_awready <= !next_aw_held;
      s_axi_wready <= !next_w_held;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= {s_axi_awaddr[7:2], 2'b00};
      end else if (wr_go) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_go) begin
        w_held <= 1'b0;
      end
    end
  end
  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= map_w ? 2'h0 : 2'h2;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end
  // register writes, only when both low byte strobes are set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      syscfg <= ommd_pkg::SYSCFG_RST;
      context_base_pointer <= ommd_pkg::CTXBASE_RST;
      stack_pointer_reg <= ommd_pkg::STKPTR_RST;
      stack_overflow_limit <= ommd_pkg::STKOVL_RST;
      stack_underflow_limit <= ommd_pkg::STKUNL_RST;
      for (int i = 0; i < 4; i++) begin
        wbase[i] <= 24'h000000;
        wmask[i] <= 24'h000000;
      end
    end else if (wr_go && w_strb[1:0] == 2'h3) begin
      case (aw_addr)
        ommd_pkg::A_SYSCFG: syscfg <= w_data[15:0];
        ommd_pkg::A_CTXBASE: context_base_pointer <= w_data[15:0];
        ommd_pkg::A_STKPTR: stack_pointer_reg <= w_data[15:0];
        ommd_pkg::A_STKOVL: stack_overflow_limit <= w_data[15:0];
        ommd_pkg::A_STKUNL: stack_underflow_limit <= w_data[15:0];
        default: begin
          if (aw_addr >= ommd_pkg::A_WIN0 && aw_addr < 8'h40) begin
            if (aw_addr[2]) begin
              wmask[wi] <= w_data[23:0];
            end else begin
              wbase[wi] <= w_data[23:0];
            end
          end
        end
      endcase
    end
  end
  // sticky stack flags; set wins over a write-one clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stack_ovf <= 1'b0;
      stack_unf <= 1'b0;
    end else begin
      stack_ovf <= (state == OMMD_S_IDLE && acc_req && sp_ovf) ||
        (stack_ovf && !(w_clr && w_data[ommd_pkg::ST_OVF]));
      stack_unf <= (state == OMMD_S_IDLE && acc_req && sp_unf) ||
        (stack_unf && !(w_clr && w_data[ommd_pkg::ST_UNF]));
    end
  end
  // read data mux
  wire [1:0] ri = ra[4:3];
  wire rd_win = ra >= ommd_pkg::A_WIN0 && ra < 8'h40;
  wire [31:0] rd_val =
    ra[7:2] == ommd_pkg::A_SYSCFG[7:2] ? {16'h0000, syscfg} :
    ra[7:2] == ommd_pkg::A_CTXBASE[7:2] ? {16'h0000, context_base_pointer} :
    ra[7:2] == ommd_pkg::A_STKPTR[7:2] ? {16'h0000, stack_pointer_reg} :
    ra[7:2] == ommd_pkg::A_STKOVL[7:2] ? {16'h0000, stack_overflow_limit} :
    ra[7:2] == ommd_pkg::A_STKUNL[7:2] ? {16'h0000, stack_underflow_limit} :
    ra[7:2] == ommd_pkg::A_STATUS[7:2] ? {30'h0, stack_unf, stack_ovf} :
    rd_win ? {8'h00, ra[2] ? wmask[ri] : wbase[ri]} : 32'h00000000;
  wire rd_ok = ra[7:2] <= ommd_pkg::A_STATUS[7:2] || rd_win;
  // read channel: one read in flight
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
      s_axi_arready <= 1'b1;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
    end else if (s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

//--- rtl/ommd_pkg.sv
// package: constants for the on-chip memory map decoder
// assumes a 24-bit byte address space and a 16-bit cpu data path
package ommd_pkg;
  // address space and region bases (byte addresses)
  localparam int ADDR_W = 24;
  localparam logic [23:0] IRAM_BASE = 24'h00F600;
  localparam logic [23:0] IRAM_LAST = 24'h00FDFF;
  localparam logic [23:0] EXTENSION_RAM_BASE = 24'h00E000;
  localparam logic [23:0] EXTENSION_RAM_LAST = 24'h00E7FF;
  localparam logic [23:0] CAN_BASE = 24'h00EF00;
  localparam logic [23:0] CAN_LAST = 24'h00EFFF;
  localparam logic [23:0] EXTENDED_FUNCTION_REGS_BASE = 24'h00F000;
  localparam logic [23:0] EXTENDED_FUNCTION_REGS_LAST = 24'h00F1FF;
  localparam logic [23:0] SFR_BASE = 24'h00FE00;
  localparam logic [23:0] SFR_LAST = 24'h00FFFF;
  localparam logic [23:0] ROM_BASE = 24'h000000;
  localparam logic [23:0] ROM_LAST = 24'h007FFF;
  // stack and register bank sizes
  localparam int STACK_BYTES = 1024;
  localparam int GPR_COUNT = 16;
  // wait states and external segment line counts
  localparam int EXTENSION_RAM_WAIT = 0;
  localparam int CAN_WAIT = 2;
  localparam int EXT_SEG_FULL = 8;
  localparam int EXT_SEG_CAN = 4;
  // timing: cycle time of the documented cpu clock and access times
  localparam int CPU_CYCLE_NS = 40;
  localparam int EXTENSION_RAM_ACCESS_NS = 80;
  localparam int CAN_ACCESS_NS = 160;
  localparam int CLK_NS = 4;
  localparam int CAN_WAIT_CYC = (CAN_WAIT * CPU_CYCLE_NS) / CLK_NS;
  // axi register map (byte addresses)
  localparam logic [7:0] A_SYSCFG = 8'h00;
  localparam logic [7:0] A_CTXBASE = 8'h04;
  localparam logic [7:0] A_STKPTR = 8'h08;
  localparam logic [7:0] A_STKOVL = 8'h0C;
  localparam logic [7:0] A_STKUNL = 8'h10;
  localparam logic [7:0] A_STATUS = 8'h14;
  localparam logic [7:0] A_WIN0 = 8'h20;
  // system configuration fields and reset values
  localparam int PERIPH_EN_BIT = 2;
  localparam logic [15:0] SYSCFG_RST = 16'h0000;
  localparam logic [15:0] STKPTR_RST = 16'hFC00;
  localparam logic [15:0] STKOVL_RST = 16'hFA00;
  localparam logic [15:0] STKUNL_RST = 16'hFC00;
  localparam logic [15:0] CTXBASE_RST = 16'hFC00;
  // status bits and window count
  localparam int ST_OVF = 0;
  localparam int ST_UNF = 1;
  localparam int NWIN = 4;
  // targets
  typedef enum logic [2:0] {
    OMMD_T_IRAM = 3'h0,
    OMMD_T_EXTENSION_RAM = 3'h1,
    OMMD_T_CAN = 3'h2,
    OMMD_T_SFR = 3'h3,
    OMMD_T_ROM = 3'h4,
    OMMD_T_EXT = 3'h5
  } ommd_target_t;
endpackage

//--- rtl/ommd_region_match.sv
// module: external window matcher with hierarchical priority
// assumes window bases and masks are stable during an access
`timescale 1ns/10ps
module ommd_region_match (
  input wire logic [23:0] addr,
  ommd_cfg_if.dst cfg,
  output logic [2:0] win_sel
);
  logic [3:0] hit; // per-window hit
  // one comparator per window
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_win
      assign hit[g] = cfg.win_mask[g] != 24'h000000 &&
        ((addr & cfg.win_mask[g]) == (cfg.win_base[g] & cfg.win_mask[g]));
    end
  endgenerate
  // window 4 over 3, window 2 over 1; otherwise default config 0
  assign win_sel = hit[3] ? 3'h4 : hit[2] ? 3'h3 :
    hit[1] ? 3'h2 : hit[0] ? 3'h1 : 3'h0;
endmodule

//--- verification/ommd_chk.sv
// checker: routing and timing relations at the decoder's ports
// assumes one clock and a cpu that holds requests until done
`timescale 1ns/10ps
module ommd_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic acc_req,
  input wire logic acc_bit,
  input wire logic acc_stack,
  input wire logic acc_gpr_en,
  input wire logic acc_done,
  input wire logic [2:0] acc_target,
  input wire logic [23:0] acc_phys,
  input wire logic [2:0] acc_busconf,
  input wire logic [3:0] seg_lines,
  input wire logic acc_fault,
  input wire logic stack_ovf
);
  logic [7:0] req_cnt; // cycles the current request has waited
  // counter restarts whenever the request drops
  always_ff @(posedge aclk) begin
    if (!aresetn || !acc_req) begin
      req_cnt <= 8'h00;
    end else if (!acc_done) begin
      req_cnt <= req_cnt + 8'h01;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_extension_ram_fast: assert property (acc_done && acc_target == 3'h1 |->
    req_cnt == 8'h01) else $error("extension_ram access not one cycle");
  a_can_wait: assert property (acc_done && acc_target == 3'h2 |->
    req_cnt == 8'h15) else $error("can access wait wrong");
  a_extension_ram_range: assert property (acc_done && acc_target == 3'h1 |->
    acc_phys inside {[24'h00E000:24'h00E7FF]}) else $error("extension_ram range");
  a_can_range: assert property (acc_done && acc_target == 3'h2 |->
    acc_phys inside {[24'h00EF00:24'h00EFFF]}) else $error("can range");
  a_can_segs: assert property (acc_done && acc_target == 3'h2 |->
    seg_lines == 4'h4) else $error("segment lines with can");
  a_extension_ram_nobit: assert property (acc_done && acc_target == 3'h1 &&
    (acc_bit || acc_stack) |-> acc_fault) else $error("extension_ram bit access");
  a_sfr_area: assert property (acc_done && !acc_gpr_en &&
    acc_phys inside {[24'h00FE00:24'h00FFFF], [24'h00F000:24'h00F1FF]}
    |-> acc_target == 3'h3) else $error("sfr area missed");
  a_rom_area: assert property (acc_done && !acc_gpr_en &&
    acc_phys <= 24'h007FFF |-> acc_target == 3'h4) else $error("rom");
  a_bank_iram: assert property (acc_done && acc_gpr_en |->
    acc_target == 3'h0) else $error("bank outside iram");
  a_done_gap: assert property (acc_done |=> !acc_done [*2])
    else $error("done pulses too close");
  a_ovf_cause: assert property ($rose(stack_ovf) |->
    $past(acc_req && acc_stack)) else $error("overflow without stack");
  c_can: cover property (acc_done && acc_target == 3'h2);
  c_ovf: cover property ($rose(stack_ovf));
  c_ext: cover property (acc_done && acc_target == 3'h5);
endmodule

//--- verification/ommd_cpu_model.sv
// partner: cpu core issuing one byte or word access at a time
// assumes the decoder pulses acc_done once for each taken request
`timescale 1ns/10ps
module ommd_cpu_model (
  input wire logic aclk,
  input wire logic acc_done,
  output logic acc_req,
  output logic [23:0] acc_addr,
  output logic acc_word,
  output logic acc_bit,
  output logic acc_stack,
  output logic [3:0] acc_gpr,
  output logic acc_gpr_en,
  output logic acc_gpr_byte,
  output logic acc_gpr_high
);
  // quiet port at time zero
  initial begin
    {acc_req, acc_word, acc_bit, acc_stack} = 4'h0;
    {acc_gpr_en, acc_gpr_byte, acc_gpr_high} = 3'h0;
    {acc_addr, acc_gpr} = 28'h5A5A5A5;
  end
  // request held until done, then one idle cycle before the next
  task automatic access(input logic [23:0] a, input logic [3:0] g,
    input logic [5:0] f);
    acc_addr <= a;
    acc_gpr <= g;
    {acc_word, acc_bit, acc_stack, acc_gpr_en, acc_gpr_byte,
      acc_gpr_high} <= f;
    acc_req <= 1'b1;
    do @(posedge aclk); while (acc_done !== 1'b1);
    acc_req <= 1'b0;
    // released lines wander so no stale address looks valid
    acc_addr <= ~a;
    acc_gpr <= ~g;
    @(posedge aclk);
  endtask
endmodule

//--- verification/ommd_decoder_tb.sv
// testbench: map model compared with the decoder at every access
// assumes the cpu model and checker files are compiled first
`timescale 1ns/10ps
module ommd_decoder_tb;
  logic aclk, aresetn, pe;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb, acc_gpr, seg_lines;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, acc_req, acc_word, acc_bit;
  logic [1:0] s_axi_bresp, s_axi_rresp, acc_lanes, r;
  logic acc_stack, acc_gpr_en, acc_gpr_byte, acc_gpr_high, acc_done;
  logic acc_fault, stack_ovf, stack_unf;
  logic [23:0] acc_addr, acc_phys;
  logic [2:0] acc_target, acc_busconf;
  logic [15:0] ctx; // context base as last written
  logic [23:0] wb [4] = '{default: 24'h0}; // window bases as written
  logic [23:0] wm [4] = '{default: 24'h0}; // window masks as written
  // window model: higher window wins, mask zero means off
  function automatic logic [2:0] win(input logic [23:0] a);
    for (int k = 3; k >= 0; k--) begin
      if (wm[k] != 24'h0 && (a & wm[k]) == (wb[k] & wm[k]))
        return 3'(k + 1);
    end
    return 3'h0;
  endfunction
  int fails = 0;
  int n_compared = 0;
  int cyc = 0;
  int seed, i, j;
  ommd_decoder u_dut (.*);
  ommd_cpu_model u_cpu (.*);
  // free-running 4 ns clock
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  // hang guard, far above the few hundred cycles the run needs
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      final_report();
    end
  end
  task automatic final_report();
    $display("compared %0d mismatched %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // bus write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
    input logic [3:0] s);
    s_axi_awaddr <= {24'h000000, a};
    s_axi_wdata <= v;
    s_axi_wstrb <= s;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= {24'h000000, a};
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  // map model: on-chip areas first, external last
  function automatic logic [2:0] tgt(input logic [23:0] a);
    if (a inside {[24'h00FE00:24'h00FFFF], [24'h00F000:24'h00F1FF]})
      return 3'h3;
    if (a inside {[24'h00F600:24'h00FDFF]}) return 3'h0;
    if (pe && a inside {[24'h00E000:24'h00E7FF]}) return 3'h1;
    if (pe && a inside {[24'h00EF00:24'h00EFFF]}) return 3'h2;
    if (a <= 24'h007FFF) return 3'h4;
    return 3'h5;
  endfunction
  // f: word, bit, stack, bank, bank byte, high byte
  task automatic acc(input logic [23:0] a, input logic [3:0] g,
    input logic [5:0] f);
    logic [23:0] p;
    logic [2:0] t;
    logic flt;
    u_cpu.access(a, g, f);
    p = f[1] ? {19'h0, 1'b0, g[2:0], f[0]} : {19'h0, g, 1'b0};
    p = f[2] ? {8'h00, ctx} + p : a;
    t = tgt(p);
    flt = ((f[3] || f[2]) && t != 3'h0) || (f[4] && t != 3'h0 && t != 3'h3);
    chk({29'h0, acc_target}, {29'h0, t});
    chk({8'h00, acc_phys}, {8'h00, p});
    chk({30'h0, acc_lanes}, {30'h0, f[5] ? 2'h3 : {p[0], !p[0]}});
    chk({28'h0, seg_lines}, pe ? 32'h4 : 32'h8);
    chk({31'h0, acc_fault}, {31'h0, flt});
    if (t == 3'h5) chk({29'h0, acc_busconf}, {29'h0, win(p)});
  endtask
  logic [23:0] am [15] = '{24'h00E000, 24'h00E7FF, 24'h00EF00,
    24'h00EFFF, 24'h00F000, 24'h00F1FF, 24'h00FE00, 24'h00FFFF,
    24'h00F600, 24'h00FDFF, 24'h000000, 24'h007FFF, 24'h008000,
    24'h00E800, 24'hFFF200};
  logic [31:0] rv [7] = '{32'h0, 32'hFC00, 32'hFC00, 32'hFA00,
    32'hFC00, 32'h0, 32'h0};
  initial begin
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    s_axi_wstrb = 4'hF;
    aresetn = 1'b0;
    seed = 32'h9043CCAE;
    pe = 1'b0;
    ctx = 16'hFC00;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (i = 0; i < 7; i++) begin
      rd(8'h04 * i[7:0]);
      chk(d, rv[i]);
      chk({30'h0, r}, i == 6 ? 32'h2 : 32'h0);
    end
    wr(8'h18, 32'h0, 4'hF);
    chk({30'h0, r}, 32'h2);
    $display("test reset values done");
    wr(8'h00, 32'h4, 4'h0);
    for (j = 0; j < 2; j++) begin
      for (i = 0; i < 15; i++) acc(am[i], 4'h0, am[i][0] ? 6'h00 : 6'h20);
      wr(8'h00, 32'h4, 4'hF);
      pe = 1'b1;
    end
    acc(24'h00E000, 4'h0, 6'h10);
    $display("test fixed map done");
    wr(8'h04, 32'hF700, 4'hF);
    ctx = 16'hF700;
    for (i = 0; i < 16; i++) acc(24'h0, i[3:0], 6'h24);
    for (i = 0; i < 16; i++) acc(24'h0, i[3:0], {5'h03, i[0]});
    $display("test register bank done");
    for (i = 0; i < 3; i++) begin
      d = i == 0 ? 32'hFB00 : (i == 1 ? 32'hF900 : 32'hFD00);
      wr(8'h08, d, 4'hF);
      acc(d[23:0], 4'h0, 6'h28);
      chk({31'h0, stack_ovf}, {31'h0, i == 1});
      chk({31'h0, stack_unf}, {31'h0, i == 2});
      rd(8'h14);
      chk(d, i == 0 ? 32'h0 : i);
      wr(8'h14, 32'h3, 4'hF);
      chk({30'h0, r}, 32'h0);
    end
    $display("test stack limits done");
    wr(8'h20, 32'h100000, 4'hF);
    wr(8'h24, 32'hF00000, 4'hF);
    wr(8'h38, 32'h120000, 4'hF);
    wr(8'h3C, 32'hFF0000, 4'hF);
    wb[0] = 24'h100000;
    wm[0] = 24'hF00000;
    wb[3] = 24'h120000;
    wm[3] = 24'hFF0000;
    rd(8'h3C);
    chk(d, 32'h00FF0000);
    acc(24'h123456, 4'h0, 6'h20);
    acc(24'h1A0000, 4'h0, 6'h20);
    acc(24'h200000, 4'h0, 6'h20);
    $display("test address windows done");
    for (j = 0; j < 2; j++) begin
      for (i = 0; i < 40; i++) begin
        d = $random(seed);
        acc(d[31] ? {8'h00, d[15:0] & ~{15'h0, d[24]}} : d[23:0],
          4'h0, {d[24], 5'h00});
      end
      wr(8'h00, 32'h0, 4'hF);
      pe = 1'b0;
    end
    $display("test random map done");
    final_report();
  end
endmodule
bind ommd_decoder ommd_chk u_chk (.*);
